/* File: core/mpra_pkg.sv */
package mpra_pkg;

    // ------------------------------------------------------------
    // Bus and register file geometry
    // ------------------------------------------------------------
    localparam int unsigned BUS_W      = 16;
    localparam int unsigned REG_AW     = 4;
    localparam int unsigned REG_COUNT  = 16;
    localparam logic [15:0] REG_RESET  = 16'h0000;

    // Command byte encodings on bus bits 0-7
    localparam logic [7:0]  CMD_SENSE  = 8'h01;
    localparam logic [7:0]  CMD_LOAD   = 8'h02;

    // Cycles a load's data phase waits after the latch strobe rises
    localparam logic [1:0]  SETTLE_CYC = 2'h1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MPRA_IDLE   = 3'b000,
        MPRA_CMD    = 3'b001,
        MPRA_READ   = 3'b010,
        MPRA_DRIVE  = 3'b011,
        MPRA_WCAP   = 3'b100,
        MPRA_ACK    = 3'b101
    } mpra_state_t;

    typedef struct packed {
        logic        latch_n;
        logic        func_n;
        logic [15:0] data;
    } mpra_bus_in_t;

    typedef struct packed {
        logic        ack_n;
        logic        oe;
        logic [15:0] data;
    } mpra_bus_out_t;

    typedef struct packed {
        logic              we;
        logic [REG_AW-1:0] addr;
        logic [15:0]       wdata;
    } mpra_wr_t;

endpackage : mpra_pkg

/* File: core/mpra_regfile.sv */
`timescale 1ns/1ps
`default_nettype none
module mpra_regfile
    import mpra_pkg::*;
(
    input  wire logic              clk_sys_in,
    input  wire logic              rst_in,
    input  wire mpra_wr_t          wr_in,
    input  wire logic [REG_AW-1:0] raddr_in,
    output var  logic [15:0]       rdata_out
);
    // ------------------------------------------------------------
    // Main processor registers
    // ------------------------------------------------------------
    logic [15:0] regs_r [REG_COUNT];

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_r[i] <= REG_RESET;
            end
        end else if (wr_in.we) begin
            regs_r[wr_in.addr] <= wr_in.wdata;
        end
    end

    // Registered read keeps the sense path a clean one-cycle access
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= REG_RESET;
        end else begin
            rdata_out <= regs_r[raddr_in];
        end
    end
endmodule : mpra_regfile
`default_nettype wire

/* File: core/mpra_port.sv */
`timescale 1ns/1ps
`default_nettype none
module mpra_port
    import mpra_pkg::*;
(
    input  wire logic          clk_sys_in,
    input  wire logic          rst_in,
    input  wire mpra_bus_in_t  bus_in,
    output var  mpra_bus_out_t bus_out,
    output var  logic [7:0]    command_out,
    output var  logic [7:0]    command_qualifier_byte_out,
    output var  logic          busy_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        mpra_state_t       st;
        logic [7:0]        cmd;
        logic [7:0]        qual;
        logic [REG_AW-1:0] addr;
        logic [15:0]       data;
        logic [1:0]        wait_cnt;
        logic              ack_n;
        logic              oe;
        logic              we;
    } mpra_ctl_t;

    mpra_ctl_t   s_r;
    mpra_ctl_t   s_nxt;
    logic [15:0] rd_data;
    mpra_wr_t    wr;

    mpra_regfile u_regs (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .wr_in      (wr),
        // Next address feeds the read so the data is ready when READ sees the strobe rise
        .raddr_in   (s_nxt.addr),
        .rdata_out  (rd_data)
    );

    // ------------------------------------------------------------
    // Handshake sequencer
    // ------------------------------------------------------------
    always_comb begin
        s_nxt    = s_r;
        s_nxt.we = 1'b0;
        unique case (s_r.st)
            MPRA_IDLE: begin
                s_nxt.ack_n = 1'b1;
                s_nxt.oe    = 1'b0;
                if (!bus_in.latch_n) begin
                    s_nxt.cmd  = bus_in.data[7:0];
                    s_nxt.qual = bus_in.data[15:8];
                    s_nxt.st   = MPRA_CMD;
                end
            end
            MPRA_CMD: begin
                if (!bus_in.func_n) begin
                    s_nxt.addr     = bus_in.data[REG_AW-1:0];
                    s_nxt.wait_cnt = SETTLE_CYC;
                    s_nxt.st       = (s_r.cmd == CMD_LOAD) ? MPRA_WCAP : MPRA_READ;
                end else if (bus_in.latch_n) begin
                    // Strobe rose without an access: abandon quietly
                    s_nxt.st = MPRA_IDLE;
                end else begin
                    s_nxt.cmd  = bus_in.data[7:0];
                    s_nxt.qual = bus_in.data[15:8];
                end
            end
            MPRA_READ: begin
                // Wait for the latch strobe to rise so the bus is free to drive
                if (bus_in.latch_n) begin
                    s_nxt.data = rd_data;
                    s_nxt.oe   = 1'b1;
                    s_nxt.st   = MPRA_DRIVE;
                end
            end
            MPRA_DRIVE: begin
                s_nxt.ack_n = 1'b0;
                s_nxt.st    = MPRA_ACK;
            end
            MPRA_WCAP: begin
                // One settle cycle after the strobe rises lets write data land
                if (bus_in.latch_n) begin
                    if (s_r.wait_cnt != 2'h0) begin
                        s_nxt.wait_cnt = s_r.wait_cnt - 2'h1;
                    end else begin
                        s_nxt.data  = bus_in.data;
                        s_nxt.ack_n = 1'b0;
                        s_nxt.we    = 1'b1;
                        s_nxt.st    = MPRA_ACK;
                    end
                end
            end
            MPRA_ACK: begin
                if (bus_in.func_n) begin
                    s_nxt.ack_n = 1'b1;
                    s_nxt.oe    = 1'b0;
                    s_nxt.st    = MPRA_IDLE;
                end
            end
            default: begin
                s_nxt.st    = MPRA_IDLE;
                s_nxt.ack_n = 1'b1;
                s_nxt.oe    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            s_r <= '{st: MPRA_IDLE, cmd: 8'h00, qual: 8'h00, addr: '0, data: 16'h0000,
                     wait_cnt: 2'h0, ack_n: 1'b1, oe: 1'b0, we: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Write lands the cycle after acknowledge asserts
    assign wr      = '{we: s_r.we, addr: s_r.addr, wdata: s_r.data};

    assign bus_out = '{ack_n: s_r.ack_n, oe: s_r.oe, data: s_r.oe ? s_r.data : 16'h0000};
    assign command_out                = s_r.cmd;
    assign command_qualifier_byte_out = s_r.qual;
    assign busy_out                   = (s_r.st != MPRA_IDLE);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sense_data_first_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $fell(bus_out.ack_n) && !s_r.we |-> $past(bus_out.oe))
        else $error("Acknowledge before sense data driven");
    ack_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !bus_out.ack_n && !bus_in.func_n |=> !bus_out.ack_n)
        else $error("Acknowledge dropped while request active");
    ack_release_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !bus_out.ack_n && bus_in.func_n |=> bus_out.ack_n && !bus_out.oe)
        else $error("Acknowledge not released after request end");
    load_write_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $fell(bus_out.ack_n) && !bus_out.oe |-> wr.we)
        else $error("Load acknowledged without register write");
    cmd_capture_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        s_r.st == MPRA_IDLE && !bus_in.latch_n |=> command_out == $past(bus_in.data[7:0])
        && command_qualifier_byte_out == $past(bus_in.data[15:8]))
        else $error("Command byte not captured");
    addr_capture_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        s_r.st == MPRA_CMD && !bus_in.func_n |=> s_r.addr == $past(bus_in.data[REG_AW-1:0]))
        else $error("Register address not captured");
    no_drive_latch_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        s_r.st == MPRA_READ && !bus_in.latch_n |=> !bus_out.oe)
        else $error("Bus driven while latch strobe low");
    sense_data_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        s_r.st == MPRA_READ && bus_in.latch_n |-> rd_data == u_regs.regs_r[s_r.addr]
        ##1 bus_out.data == $past(rd_data))
        else $error("Sense data differs from register");

    sense_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        s_r.st == MPRA_DRIVE ##1 s_r.st == MPRA_ACK);
    load_c: cover property (@(posedge clk_sys_in) disable iff (rst_in) wr.we);
    abandon_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        s_r.st == MPRA_CMD && bus_in.latch_n && bus_in.func_n);
endmodule : mpra_port
`default_nettype wire

/* File: tb/mpra_req_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mpra_req_model
    import mpra_pkg::*;
(
    input  wire logic          clk_sys_in,
    input  wire mpra_bus_out_t bus_in,
    output var  mpra_bus_in_t  bus_out,
    output var  logic          timeout_out
);
    initial begin
        bus_out     = '{latch_n: 1'b1, func_n: 1'b1, data: 16'h0000};
        timeout_out = 1'b0;
    end
    // ------------------------------------------------------------
    // Accesses; a released bus shows the inverse of its last word
    // ------------------------------------------------------------
    task automatic access(input logic [7:0] cmd, input logic [7:0] qual,
                          input logic [15:0] addr, input logic [15:0] wd,
                          output logic [15:0] rd);
        int n;
        rd = 16'h0000;
        @(posedge clk_sys_in);
        bus_out.latch_n <= 1'b0;
        bus_out.data    <= {qual, cmd};
        @(posedge clk_sys_in);
        bus_out.func_n  <= 1'b0;
        bus_out.data    <= addr;
        @(posedge clk_sys_in);
        bus_out.latch_n <= 1'b1;
        bus_out.data    <= (cmd == CMD_LOAD) ? wd : ~addr;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (bus_in.ack_n !== 1'b0 && n < 40);
        if (bus_in.ack_n !== 1'b0) timeout_out <= 1'b1;
        rd = bus_in.data;
        bus_out.func_n  <= 1'b1;
        bus_out.data    <= ~bus_out.data;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (bus_in.ack_n !== 1'b1 && n < 40);
        // A stuck acknowledge either way ends the run
        if (bus_in.ack_n !== 1'b1) timeout_out <= 1'b1;
        @(posedge clk_sys_in);
    endtask : access

    task automatic abort(input logic [15:0] w);
        @(posedge clk_sys_in);
        bus_out.latch_n <= 1'b0;
        bus_out.data    <= w;
        @(posedge clk_sys_in);
        bus_out.latch_n <= 1'b1;
        bus_out.data    <= ~w;
    endtask : abort
endmodule : mpra_req_model
`default_nettype wire

/* File: tb/main_proc_register_access_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module main_proc_register_access_port_tb
    import mpra_pkg::*;
;
    typedef struct packed {
        logic        sense;
        logic [15:0] cmdq;
        logic [15:0] data;
    } mpra_exp_t;
    logic          clk_sys_in = 1'b0;
    logic          rst_in     = 1'b1;
    mpra_bus_in_t  bus_in;
    mpra_bus_out_t bus_out;
    logic [7:0]    command;
    logic [7:0]    qual_byte;
    logic          busy;
    logic          timeout;
    logic          ack_prev = 1'b1;
    logic [31:0]   seed     = 32'h00008A9A;
    logic [15:0]   model_mem [REG_COUNT];
    mpra_exp_t     exp_q [$];
    mpra_exp_t     got;
    int            errors     = 0;
    int            n_compared = 0;

    initial forever #4 clk_sys_in = ~clk_sys_in;

    mpra_port dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus_in(bus_in),
        .bus_out(bus_out), .command_out(command),
        .command_qualifier_byte_out(qual_byte), .busy_out(busy));
    mpra_req_model req_u (.clk_sys_in(clk_sys_in), .bus_in(bus_out),
        .bus_out(bus_in), .timeout_out(timeout));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction : rnd

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    // Model memory mirrors writes so a later sense predicts the load
    task automatic run(input logic [7:0] cmd, input logic [15:0] addr, input logic [15:0] wd);
        logic [15:0] r;
        logic [15:0] rd;
        mpra_exp_t   e;
        r       = rnd();
        e.sense = (cmd != CMD_LOAD);
        e.cmdq  = {r[7:0], cmd};
        e.data  = e.sense ? model_mem[addr[3:0]] : wd;
        if (!e.sense) model_mem[addr[3:0]] = wd;
        exp_q.push_back(e);
        req_u.access(cmd, r[7:0], addr, wd, rd);
        if (e.sense) check(rd, e.data);
        check({14'h0000, bus_out.ack_n, bus_out.oe}, 16'h0002);
    endtask : run

    // ------------------------------------------------------------
    // Watcher: one note consumed per acknowledge
    // ------------------------------------------------------------
    always @(posedge clk_sys_in) begin
        if (!rst_in && bus_out.ack_n === 1'b0 && ack_prev === 1'b1) begin
            check({15'h0000, exp_q.size() > 0}, 16'h0001);
            if (exp_q.size() > 0) begin
                got = exp_q.pop_front();
                check({qual_byte, command}, got.cmdq);
                check({15'h0000, bus_out.oe}, {15'h0000, got.sense});
                if (got.sense) check(bus_out.data, got.data);
            end
        end
        ack_prev <= bus_out.ack_n;
    end

    always @(posedge timeout) begin
        errors++;
        final_report();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] a;
        for (int i = 0; i < REG_COUNT; i++) model_mem[i] = REG_RESET;
        repeat (3) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        check({13'h0000, bus_out.ack_n, bus_out.oe, busy}, 16'h0004);
        check({qual_byte, command}, 16'h0000);
        run(CMD_SENSE, 16'h0005, 16'h0000);
        req_u.abort(16'h5A02);
        repeat (2) @(posedge clk_sys_in);
        check({15'h0000, busy}, 16'h0000);
        for (int i = 0; i < 24; i++) begin
            a = rnd();
            run(CMD_LOAD, a, rnd());
            run((i % 2 == 0) ? CMD_SENSE : 8'h7F, a ^ 16'hFFF0, 16'h0000);
            run(rnd() > 16'h7FFF ? CMD_LOAD : CMD_SENSE, rnd(), rnd());
        end
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge clk_sys_in);
        check(16'(exp_q.size()), 16'h0000);
        final_report();
    end
endmodule : main_proc_register_access_port_tb
`default_nettype wire
